// >>> rtl/system_state_regs.sv
// Status and flag register bank of the system state controller
//
// Design decision made here: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module system_state_regs
  import system_state_pkg::*;
(
  // Clock, reset, enable
  input  wire logic                                  clk,
  input  wire logic                                  rst,
  input  wire logic                                  ce,
  // Avalon-MM slave
  input  wire logic [system_state_pkg::ADDR_W-1:0]   address,
  input  wire logic                                  read,
  input  wire logic                                  write,
  input  wire logic [system_state_pkg::DATA_W-1:0]   writedata,
  input  wire logic [3:0]                            byteenable,
  output logic      [system_state_pkg::DATA_W-1:0]   readdata,
  output logic                                       waitrequest,
  // Break state
  input  wire logic                                  break_active,
  input  wire logic                                  break_wait_set,
  output logic                                       status_clear_allow,
  // Reset cause pins: pin, watchdog, opcode, address, monitor, brownout
  input  wire logic [system_state_pkg::RST_SOURCES-1:0] reset_cause_async,
  // Interrupt sources 21..1 in bits 20..0
  input  wire logic [system_state_pkg::IRQ_SOURCES-1:0] irq_source_flags,
  // Clock output and interrupt
  output logic                                       bus_clk,
  output logic                                       irq
);
  import system_state_pkg::*;

  logic                      ack_q;
  logic                      acc;
  logic                      rd_acc;
  logic                      wr_acc;
  logic [IDX_W-1:0]          idx;
  logic                      bus_clk_q;
  logic                      break_wait_q;
  logic [REG_W-1:0]          reset_status_q;
  logic                      clear_en_q;
  logic [IRQ_SOURCES-1:0]    flags_q;
  logic [IRQ_SOURCES-1:0]    flags_prev_q;
  logic [REG_W-1:0]          flags_low;
  logic [REG_W-1:0]          flags_mid;
  logic [REG_W-1:0]          flags_high;
  logic [REG_W-1:0]          irq_status_q;
  logic [REG_W-1:0]          irq_status_d;
  logic [REG_W-1:0]          irq_mask_q;
  logic [REG_W-1:0]          events;
  logic [REG_W-1:0]          rd_mux;
  logic [DATA_W-1:0]         readdata_q;
  logic [RST_SOURCES-1:0]    cause_lvl;
  logic [RST_SOURCES-1:0]    cause_prev_q;
  logic [RST_SOURCES-1:0]    cause_rise;
  logic [RST_SOURCES-1:0]    cause_bits;
  logic                      lane0;

  // Bus handshake: one wait cycle, answer on the second edge; no answer while frozen
  assign waitrequest = ~(ack_q & ce);
  assign acc         = (read | write) & ack_q & ce;
  assign rd_acc      = read & acc;
  assign wr_acc      = write & acc & lane0;
  assign lane0       = byteenable[0];
  assign idx         = address[ADDR_W-1:2];
  assign readdata    = readdata_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      ack_q <= 1'b0;
    end else if (ce) begin
      ack_q <= (read | write) & ~ack_q;
    end
  end

  // Bus clock toggles every enabled cycle: half the input rate
  always_ff @(posedge clk) begin
    if (rst) begin
      bus_clk_q <= 1'b0;
    end else if (ce) begin
      bus_clk_q <= ~bus_clk_q;
    end
  end
  assign bus_clk = bus_clk_q;

  // Break protection of status flags
  assign status_clear_allow = ~break_active | clear_en_q;

  // Break flag control register
  always_ff @(posedge clk) begin
    if (rst) begin
      clear_en_q <= 1'b0;
    end else if (ce && wr_acc && idx == IDX_BREAK_CTRL) begin
      clear_en_q <= writedata[CLEAR_EN_BIT];
    end
  end

  // Break-wait flag: set wins over a write-zero clear
  always_ff @(posedge clk) begin
    if (rst) begin
      break_wait_q <= 1'b0;
    end else if (ce) begin
      if (break_wait_set) begin
        break_wait_q <= 1'b1;
      end else if (wr_acc && idx == IDX_BREAK_STATUS && !writedata[BREAK_WAIT_BIT]
                   && status_clear_allow) begin
        break_wait_q <= 1'b0;
      end
    end
  end

  // Reset cause pins come from outside the clock domain
  pin_sync #(
    .W        (RST_SOURCES)
  ) u_cause_sync (
    .clk      (clk),
    .rst      (rst),
    .ce       (ce),
    .async_in (reset_cause_async),
    .level_q  (cause_lvl)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      cause_prev_q <= '0;
    end else if (ce) begin
      cause_prev_q <= cause_lvl;
    end
  end
  assign cause_rise = cause_lvl & ~cause_prev_q;

  // Pin cause lands in bit 6, brownout in bit 1
  genvar c;
  generate
    for (c = 0; c < RST_SOURCES; c++) begin : g_cause
      assign cause_bits[c] = cause_rise[RST_SOURCES-1-c];
    end
  endgenerate

  // Reset status: power-on value, causes recorded in bits 6..1
  always_ff @(posedge clk) begin
    if (rst) begin
      reset_status_q <= RESET_STATUS_POR;
    end else if (ce) begin
      reset_status_q <= reset_status_q | {1'b0, cause_bits, 1'b0};
    end
  end

  // Interrupt source flags captured per source
  genvar s;
  generate
    for (s = 0; s < IRQ_SOURCES; s++) begin : g_src
      always_ff @(posedge clk) begin
        if (rst) begin
          flags_q[s]      <= 1'b0;
          flags_prev_q[s] <= 1'b0;
        end else if (ce) begin
          flags_q[s]      <= irq_source_flags[s];
          flags_prev_q[s] <= flags_q[s];
        end
      end
    end
  endgenerate

  assign flags_low  = {flags_q[LOW_COUNT-1:0], {LOW_SHIFT{1'b0}}};
  assign flags_mid  = flags_q[HIGH_BASE-1:MID_BASE];
  assign flags_high = {1'b0, flags_q[IRQ_SOURCES-1:HIGH_BASE]};

  // Sticky event status, cleared by a read; a new event wins
  always_comb begin
    events                 = REG_ZERO;
    events[EV_BREAK_WAIT]  = break_wait_set & ~break_wait_q;
    events[EV_RESET_CAUSE] = |cause_rise;
    events[EV_IRQ_RISE]    = |(flags_q & ~flags_prev_q);
    irq_status_d           = irq_status_q;
    // Clear only what the read returned, so an event from the wait cycle survives
    if (rd_acc && idx == IDX_IRQ_STATUS && status_clear_allow) begin
      irq_status_d = irq_status_q & ~readdata_q[REG_W-1:0];
    end
    irq_status_d = (irq_status_d | events) & IRQ_EVENT_MASK;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_status_q <= REG_ZERO;
    end else if (ce) begin
      irq_status_q <= irq_status_d;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_mask_q <= REG_ZERO;
    end else if (ce && wr_acc && idx == IDX_IRQ_MASK) begin
      irq_mask_q <= writedata[REG_W-1:0] & IRQ_EVENT_MASK;
    end
  end

  assign irq = |(irq_status_q & irq_mask_q);

  // Read multiplexer; unmapped and reserved bits read zero
  always_comb begin
    rd_mux = REG_ZERO;
    case (idx)
      IDX_BREAK_STATUS: rd_mux[BREAK_WAIT_BIT] = break_wait_q;
      IDX_RESET_STATUS: rd_mux = reset_status_q;
      IDX_BREAK_CTRL:   rd_mux[CLEAR_EN_BIT] = clear_en_q;
      IDX_FLAGS_LOW:    rd_mux = flags_low;
      IDX_FLAGS_MID:    rd_mux = flags_mid;
      IDX_FLAGS_HIGH:   rd_mux = flags_high;
      IDX_IRQ_STATUS:   rd_mux = irq_status_q;
      IDX_IRQ_MASK:     rd_mux = irq_mask_q;
      default:          rd_mux = REG_ZERO;
    endcase
  end

  // Read data loaded in the wait cycle, stands at the answer edge
  always_ff @(posedge clk) begin
    if (rst) begin
      readdata_q <= UNMAPPED_DATA;
    end else if (ce && read && !ack_q) begin
      readdata_q <= {{(DATA_W-REG_W){1'b0}}, rd_mux};
    end
  end

  // Checks
  AST_BUS_CLK_HALF: assert property (@(posedge clk) disable iff (rst)
    ce |=> bus_clk != $past(bus_clk))
    else $error("bus clock did not toggle on an enabled cycle");

  AST_WAIT_ONE: assert property (@(posedge clk) disable iff (rst)
    (read || write) && waitrequest && ce |=> ack_q && (waitrequest == !ce))
    else $error("waitrequest held longer than one cycle");

  AST_BREAK_CLEAR: assert property (@(posedge clk) disable iff (rst)
    wr_acc && idx == IDX_BREAK_STATUS && !writedata[BREAK_WAIT_BIT] && status_clear_allow
    && !break_wait_set |=> !break_wait_q)
    else $error("break-wait flag not cleared by write of zero");

  AST_RESET_BIT0: assert property (@(posedge clk) disable iff (rst)
    reset_status_q[0] == 1'b0 and (rd_acc && idx == IDX_RESET_STATUS |-> readdata[0] == 1'b0))
    else $error("reset status bit 0 not zero");

  AST_POR_VALUE: assert property (@(posedge clk) disable iff (rst)
    $fell(rst) |-> reset_status_q == RESET_STATUS_POR)
    else $error("reset status wrong after power-on reset");

  AST_CLEAR_EN_WRITE: assert property (@(posedge clk) disable iff (rst)
    wr_acc && idx == IDX_BREAK_CTRL |=> clear_en_q == $past(writedata[CLEAR_EN_BIT]))
    else $error("clear-enable bit not written");

  AST_BREAK_PROTECT: assert property (@(posedge clk) disable iff (rst)
    break_active && !clear_en_q && (break_wait_q || irq_status_q != REG_ZERO)
    |=> break_wait_q >= $past(break_wait_q) && (irq_status_q & $past(irq_status_q)) == $past(irq_status_q))
    else $error("status cleared during protected break state");

  AST_FLAGS_LOW: assert property (@(posedge clk) disable iff (rst)
    ce ##1 ce |=> flags_low == {$past(irq_source_flags[LOW_COUNT-1:0]), 2'b00})
    else $error("flags low register mismatch");

  AST_FLAGS_MID: assert property (@(posedge clk) disable iff (rst)
    ce |=> flags_mid == $past(irq_source_flags[HIGH_BASE-1:MID_BASE]))
    else $error("flags mid register mismatch");

  AST_FLAGS_HIGH: assert property (@(posedge clk) disable iff (rst)
    ce |=> flags_high == {1'b0, $past(irq_source_flags[IRQ_SOURCES-1:HIGH_BASE])})
    else $error("flags high register mismatch");

  AST_RO_WRITE: assert property (@(posedge clk) disable iff (rst)
    wr_acc && idx == IDX_RESET_STATUS && cause_rise == '0 |=> reset_status_q == $past(reset_status_q))
    else $error("write changed read-only reset status");

  AST_WAIT_IDLE: assert property (@(posedge clk) disable iff (rst)
    !read && !write && ce |=> waitrequest)
    else $error("waitrequest low without a request");

  AST_READ_UPPER: assert property (@(posedge clk) disable iff (rst)
    rd_acc |-> readdata[DATA_W-1:REG_W] == '0)
    else $error("upper read data bits not zero");

  AST_BREAK_RSVD: assert property (@(posedge clk) disable iff (rst)
    rd_acc && idx == IDX_BREAK_STATUS
    |-> readdata[REG_W-1:BREAK_WAIT_BIT+1] == '0 && readdata[BREAK_WAIT_BIT-1:0] == '0)
    else $error("reserved break status bits not zero");

  AST_BREAK_SET: assert property (@(posedge clk) disable iff (rst)
    ce && break_wait_set |=> break_wait_q)
    else $error("break-wait flag not set");

  AST_CTRL_RSVD: assert property (@(posedge clk) disable iff (rst)
    rd_acc && idx == IDX_BREAK_CTRL |-> readdata[CLEAR_EN_BIT-1:0] == '0)
    else $error("reserved control bits not zero");

  AST_CLEAR_EN_HOLD: assert property (@(posedge clk) disable iff (rst)
    !(wr_acc && idx == IDX_BREAK_CTRL) |=> $stable(clear_en_q))
    else $error("clear-enable bit changed without a write");

  AST_CAUSE_PIN: assert property (@(posedge clk) disable iff (rst)
    ce && cause_rise[0] |=> reset_status_q[POR_BIT-1])
    else $error("pin reset cause not recorded in bit 6");

  AST_CAUSE_BROWNOUT: assert property (@(posedge clk) disable iff (rst)
    ce && cause_rise[RST_SOURCES-1] |=> reset_status_q[POR_BIT-RST_SOURCES])
    else $error("brownout reset cause not recorded in bit 1");

  AST_CAUSE_STICKY: assert property (@(posedge clk) disable iff (rst)
    ce |=> (reset_status_q & $past(reset_status_q)) == $past(reset_status_q))
    else $error("recorded reset cause lost");

  AST_FLAGS_LOW_PAD: assert property (@(posedge clk) disable iff (rst)
    rd_acc && idx == IDX_FLAGS_LOW |-> readdata[LOW_SHIFT-1:0] == '0)
    else $error("flags low padding bits not zero");

  AST_FLAGS_HIGH_PAD: assert property (@(posedge clk) disable iff (rst)
    rd_acc && idx == IDX_FLAGS_HIGH |-> readdata[REG_W-1] == 1'b0)
    else $error("flags high top bit not zero");

  AST_BUS_CLK_FROZEN: assert property (@(posedge clk) disable iff (rst)
    !ce |=> $stable(bus_clk))
    else $error("bus clock moved while frozen");

  AST_MASK_WRITE: assert property (@(posedge clk) disable iff (rst)
    wr_acc && idx == IDX_IRQ_MASK |=> irq_mask_q == ($past(writedata[REG_W-1:0]) & IRQ_EVENT_MASK))
    else $error("interrupt mask not written");

  AST_STATUS_STICKY: assert property (@(posedge clk) disable iff (rst)
    !(rd_acc && idx == IDX_IRQ_STATUS) |=> (irq_status_q & $past(irq_status_q)) == $past(irq_status_q))
    else $error("interrupt status bit dropped without a read");

  AST_EVENT_KEPT: assert property (@(posedge clk) disable iff (rst)
    ce && break_wait_set && !break_wait_q |=> irq_status_q[EV_BREAK_WAIT])
    else $error("break-wait event not recorded");

  AST_SOURCE_EVENT: assert property (@(posedge clk) disable iff (rst)
    ce && (flags_q & ~flags_prev_q) != '0 |=> irq_status_q[EV_IRQ_RISE])
    else $error("source flag event not recorded");

  AST_CAUSE_EVENT: assert property (@(posedge clk) disable iff (rst)
    ce && cause_rise != '0 |=> irq_status_q[EV_RESET_CAUSE])
    else $error("reset cause event not recorded");

  AST_READ_CLEARS: assert property (@(posedge clk) disable iff (rst)
    rd_acc && idx == IDX_IRQ_STATUS && status_clear_allow && events == REG_ZERO
    |=> (irq_status_q & $past(readdata[REG_W-1:0])) == REG_ZERO)
    else $error("interrupt status bits not cleared by read");

  COV_BREAK_CLEARED: cover property (@(posedge clk) disable iff (rst)
    break_wait_q ##1 !break_wait_q);
  COV_IRQ_RAISED: cover property (@(posedge clk) disable iff (rst)
    !irq ##1 irq);
  COV_STATUS_READ: cover property (@(posedge clk) disable iff (rst)
    rd_acc && idx == IDX_IRQ_STATUS && irq_status_q != REG_ZERO);
  COV_PROTECTED: cover property (@(posedge clk) disable iff (rst)
    break_active && !clear_en_q && rd_acc && idx == IDX_IRQ_STATUS);
  COV_CAUSE_RECORDED: cover property (@(posedge clk) disable iff (rst)
    cause_rise != '0);

endmodule : system_state_regs
`default_nettype wire

// >>> rtl/system_state_pkg.sv
// Constants shared by the system state status register bank
package system_state_pkg;
  localparam int          ADDR_W        = 18;
  localparam int          DATA_W        = 32;
  localparam int          REG_W         = 8;
  localparam int          IDX_W         = 16;
  localparam int          IRQ_SOURCES   = 21;
  localparam int          IRQ_SOURCES_MAX = 128;
  localparam int          RST_SOURCES   = 6;
  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_BREAK_STATUS = 16'hfe00;
  localparam logic [15:0] IDX_RESET_STATUS = 16'hfe01;
  localparam logic [15:0] IDX_BREAK_CTRL   = 16'hfe03;
  localparam logic [15:0] IDX_FLAGS_LOW    = 16'hfe04;
  localparam logic [15:0] IDX_FLAGS_MID    = 16'hfe05;
  localparam logic [15:0] IDX_FLAGS_HIGH   = 16'hfe06;
  localparam logic [15:0] IDX_IRQ_STATUS   = 16'hfe08;
  localparam logic [15:0] IDX_IRQ_MASK     = 16'hfe09;
  // Field positions
  localparam int          BREAK_WAIT_BIT   = 1;
  localparam int          CLEAR_EN_BIT     = 7;
  localparam int          POR_BIT          = 7;
  localparam int          LOW_SHIFT        = 2;
  localparam int          LOW_COUNT        = 6;
  localparam int          MID_BASE         = 6;
  localparam int          HIGH_BASE        = 14;
  localparam int          EV_BREAK_WAIT    = 0;
  localparam int          EV_RESET_CAUSE   = 1;
  localparam int          EV_IRQ_RISE      = 2;
  // Reset values and event mask
  localparam logic [7:0]  REG_ZERO         = 8'h00;
  localparam logic [7:0]  RESET_STATUS_POR = 8'h80;
  localparam logic [7:0]  IRQ_EVENT_MASK   = 8'h07;
  localparam logic [31:0] UNMAPPED_DATA    = 32'h0000_0000;
endpackage : system_state_pkg

// >>> rtl/pin_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int W = 1
) (
  // Clock and control
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         ce,
  // Asynchronous inputs and filtered levels
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] level_q
);
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic s1_q;
      logic s2_q;
      logic s3_q;
      always_ff @(posedge clk) begin
        if (rst) begin
          s1_q       <= 1'b0;
          s2_q       <= 1'b0;
          s3_q       <= 1'b0;
          level_q[i] <= 1'b0;
        end else if (ce) begin
          s1_q <= async_in[i];
          s2_q <= s1_q;
          s3_q <= s2_q;
          // A change counts once the second and third stages agree
          if (s2_q == s3_q) begin
            level_q[i] <= s3_q;
          end
        end
      end
    end
  endgenerate
endmodule : pin_sync
`default_nettype wire

// >>> sim/cpu_bus_master.sv
// Avalon-MM master standing in for the CPU core
`timescale 1ns/1ps
`default_nettype none
module cpu_bus_master (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Command side
  input  wire logic        start,
  input  wire logic        op_wr,
  input  wire logic [17:0] op_addr,
  input  wire logic [7:0]  op_data,
  input  wire logic        op_be,
  output logic             done = 1'b0,
  output logic [31:0]      rdata = 32'h0000_0000,
  // Avalon-MM master
  output logic [17:0]      address = 18'h0_0000,
  output logic             read = 1'b0,
  output logic             write = 1'b0,
  output logic [31:0]      writedata = 32'h0000_0000,
  output logic [3:0]       byteenable = 4'hf,
  input  wire logic [31:0] readdata,
  input  wire logic        waitrequest
);
  always @(posedge clk) begin
    done <= 1'b0;
    if (rst) begin
      read  <= 1'b0;
      write <= 1'b0;
    end else if ((read || write) && !waitrequest) begin
      read      <= 1'b0;
      write     <= 1'b0;
      rdata     <= readdata;
      done      <= 1'b1;
      // Released lines stop showing the last value
      address   <= ~address;
      writedata <= ~writedata;
    end else if (start && !read && !write) begin
      address    <= op_addr;
      read       <= !op_wr;
      write      <= op_wr;
      writedata  <= {24'h00_0000, op_data};
      byteenable <= {3'h7, op_be};
    end
  end
endmodule // cpu_bus_master
`default_nettype wire

// >>> sim/system_state_status_registers_tb.sv
// Self-checking bench for the system state status register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("MISMATCH %s expected %h seen %h", nm, exp, got); end end
module system_state_status_registers_tb;
  import system_state_pkg::*;
  typedef struct {logic [20:0] src; logic [15:0] idx; logic [7:0] val;} row_t;
  logic        clk = 1'b0, rst = 1'b1, ce = 1'b1, brk_act = 1'b0, bw_set = 1'b0;
  logic        start = 1'b0, op_wr = 1'b0, op_be = 1'b1, b0;
  logic        done, bus_clk, irq, clr_ok, rd, wr_s, wrq;
  logic [5:0]  causes = 6'h00;
  logic [20:0] srcs = 21'h00_0000;
  logic [7:0]  op_data = 8'h00;
  logic [17:0] op_addr = 18'h0_0000, address;
  logic [31:0] rdata, wdata, readdata, q;
  logic [3:0]  be;
  int          n_mismatch = 0, checked = 0, cyc = 0;
  row_t rows [15] = '{
    '{21'h00_0000, IDX_BREAK_STATUS, 8'h00}, '{21'h00_0000, IDX_RESET_STATUS, 8'h80},
    '{21'h00_0000, IDX_BREAK_CTRL, 8'h00}, '{21'h00_0000, IDX_FLAGS_LOW, 8'h00},
    '{21'h00_0000, IDX_FLAGS_MID, 8'h00}, '{21'h00_0000, IDX_FLAGS_HIGH, 8'h00},
    '{21'h00_0000, 16'hfe02, 8'h00}, '{21'h00_0000, IDX_IRQ_STATUS, 8'h00},
    '{21'h00_0000, IDX_IRQ_MASK, 8'h00}, '{21'h00_003f, IDX_FLAGS_LOW, 8'hfc},
    '{21'h00_0001, IDX_FLAGS_LOW, 8'h04}, '{21'h00_3fc0, IDX_FLAGS_MID, 8'hff},
    '{21'h00_0040, IDX_FLAGS_MID, 8'h01}, '{21'h1f_c000, IDX_FLAGS_HIGH, 8'h7f},
    '{21'h10_0000, IDX_FLAGS_HIGH, 8'h40}};

  system_state_regs system_state_regs_inst (
    .clk(clk), .rst(rst), .ce(ce), .address(address), .read(rd), .write(wr_s),
    .writedata(wdata), .byteenable(be), .readdata(readdata), .waitrequest(wrq),
    .break_active(brk_act), .break_wait_set(bw_set), .status_clear_allow(clr_ok),
    .reset_cause_async(causes), .irq_source_flags(srcs), .bus_clk(bus_clk), .irq(irq));

  cpu_bus_master cpu_bus_master_inst (
    .clk(clk), .rst(rst), .start(start), .op_wr(op_wr), .op_addr(op_addr),
    .op_data(op_data), .op_be(op_be), .done(done), .rdata(rdata), .address(address),
    .read(rd), .write(wr_s), .writedata(wdata), .byteenable(be), .readdata(readdata),
    .waitrequest(wrq));

  initial begin
    forever #20 clk = ~clk;
  end

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      test_done();
    end
  end

  task automatic bus(input logic w, input logic [15:0] idx, input logic [7:0] d);
    @(posedge clk);
    start   <= 1'b1;
    op_wr   <= w;
    op_addr <= {idx, 2'b00};
    op_data <= d;
    @(posedge clk);
    start <= 1'b0;
    while (done !== 1'b1) @(posedge clk);
    q = rdata;
  endtask

  task automatic chk(input logic [15:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    `CHK($sformatf("register %h", idx), {24'h00_0000, exp}, q)
  endtask

  task automatic pulse_bw();
    @(posedge clk);
    bw_set <= 1'b1;
    @(posedge clk);
    bw_set <= 1'b0;
  endtask

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      srcs <= rows[i].src;
      repeat (2) @(posedge clk);
      chk(rows[i].idx, rows[i].val);
    end
    srcs <= 21'h00_0000;
    bus(1'b1, IDX_RESET_STATUS, 8'h00);
    bus(1'b1, IDX_FLAGS_LOW, 8'hff);
    chk(IDX_RESET_STATUS, 8'h80);
    chk(IDX_FLAGS_LOW, 8'h00);
    bus(1'b1, IDX_BREAK_CTRL, 8'hff);
    chk(IDX_BREAK_CTRL, 8'h80);
    bus(1'b1, IDX_BREAK_CTRL, 8'h00);
    chk(IDX_BREAK_CTRL, 8'h00);
    pulse_bw();
    chk(IDX_BREAK_STATUS, 8'h02);
    bus(1'b1, IDX_BREAK_STATUS, 8'hff);
    chk(IDX_BREAK_STATUS, 8'h02);
    op_be <= 1'b0;
    bus(1'b1, IDX_BREAK_STATUS, 8'h00);
    op_be <= 1'b1;
    chk(IDX_BREAK_STATUS, 8'h02);
    // Break state with clear-enable low protects the flag
    brk_act <= 1'b1;
    bus(1'b1, IDX_BREAK_STATUS, 8'h00);
    chk(IDX_BREAK_STATUS, 8'h02);
    `CHK("clear allow", 1'b0, clr_ok)
    bus(1'b1, IDX_BREAK_CTRL, 8'h80);
    `CHK("clear allow", 1'b1, clr_ok)
    bus(1'b1, IDX_BREAK_STATUS, 8'h00);
    chk(IDX_BREAK_STATUS, 8'h00);
    brk_act <= 1'b0;
    causes <= 6'h02;
    repeat (10) @(posedge clk);
    chk(IDX_RESET_STATUS, 8'ha0);
    causes <= 6'h3f;
    repeat (10) @(posedge clk);
    chk(IDX_RESET_STATUS, 8'hfe);
    causes <= 6'h00;
    repeat (10) @(posedge clk);
    chk(IDX_RESET_STATUS, 8'hfe);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    chk(IDX_RESET_STATUS, 8'h80);
    chk(IDX_BREAK_CTRL, 8'h00);
    // Interrupt raised, masked, unmasked and cleared by reading
    pulse_bw();
    repeat (2) @(posedge clk);
    `CHK("irq masked", 1'b0, irq)
    bus(1'b1, IDX_IRQ_MASK, 8'hff);
    chk(IDX_IRQ_MASK, 8'h07);
    `CHK("irq", 1'b1, irq)
    chk(IDX_IRQ_STATUS, 8'h01);
    `CHK("irq cleared", 1'b0, irq)
    srcs <= 21'h00_0100;
    repeat (3) @(posedge clk);
    `CHK("irq", 1'b1, irq)
    // Break state with clear-enable low keeps the status through reads
    brk_act <= 1'b1;
    chk(IDX_IRQ_STATUS, 8'h04);
    chk(IDX_IRQ_STATUS, 8'h04);
    brk_act <= 1'b0;
    chk(IDX_IRQ_STATUS, 8'h04);
    chk(IDX_IRQ_STATUS, 8'h00);
    b0 = bus_clk;
    @(posedge clk);
    `CHK("bus clock", ~b0, bus_clk)
    ce <= 1'b0;
    @(posedge clk);
    b0 = bus_clk;
    @(posedge clk);
    `CHK("bus clock held", b0, bus_clk)
    ce <= 1'b1;
    test_done();
  end
endmodule // system_state_status_registers_tb
`default_nettype wire
